//--- hw/hsfs_pkg.sv
// package of the high-side switch supervisor controller (host side)
// assumes one 10 MHz clock and a synchronous active-low reset
package hsfs_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned HOLD_US_PER_NF  = 50;
  localparam int unsigned CAP_MIN_NF      = 10;
  localparam int unsigned CAP_MAX_NF      = 100;
  localparam int unsigned CAP_DEF_NF      = 10;
  localparam int unsigned RESTART_FACTOR  = 32;
  localparam int unsigned MASK_MAX_US     = 200;
  localparam int unsigned COLD_HOLD_US_LO = 100;
  localparam int unsigned COLD_HOLD_US_HI = 50;
  // one-microsecond tick from the 10 MHz clock
  localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000;
  localparam int unsigned HOLD_DEF_US     = HOLD_US_PER_NF * CAP_DEF_NF;
  localparam int unsigned RESTART_DEF_US  = RESTART_FACTOR * HOLD_DEF_US;
  localparam int unsigned CNT_W           = 16;
  typedef enum logic [2:0] {
    HSFS_ST_OFF, HSFS_ST_ON, HSFS_ST_LIMIT, HSFS_ST_WAIT, HSFS_ST_HOT
  } hsfs_state_t;
endpackage

//--- hw/hsfs_tick.sv
// microsecond enable divider
// assumes the package tick constant matches the clock rate
module hsfs_tick (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  // tick out
  output logic      o_tick
);
  import hsfs_pkg::*;
  logic [7:0] div_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      div_q  <= 8'h00;
      o_tick <= 1'b0;
    end else if (div_q == 8'(TICK_CYC - 1)) begin
      div_q  <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

//--- hw/hsfs_ctrl.sv
// host-side supervisor of a high-side switch: drives the command pin,
// keeps a model of the protection state and watches the fault indicator
// assumes all pin inputs are synchronous to i_clk_sys
module hsfs_ctrl #(
  parameter int unsigned HOLD_US    = hsfs_pkg::HOLD_DEF_US,
  parameter int unsigned RESTART_US = hsfs_pkg::RESTART_DEF_US,
  parameter int unsigned MASK_US    = hsfs_pkg::MASK_MAX_US
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // comparator levels
  input  wire logic        i_supply_ok,
  input  wire logic        i_supply_low,
  input  wire logic        i_over_temp,
  input  wire logic        i_temp_cooled,
  input  wire logic        i_over_current,
  input  wire logic        i_out_high,
  // device pins
  output logic             o_switch_cmd,
  input  wire logic        i_fault_indicator_n,
  output logic             o_fault_indicator_n_o,
  output logic             o_fault_indicator_n_oe,
  // status
  output logic             o_out_enable,
  output logic             o_thermal_flag,
  output logic             o_cutoff_flag,
  output logic             o_open_load_flag,
  output logic             o_fault_mismatch
);
  import hsfs_pkg::*;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  logic        tick;
  logic        cmd_q, cut_en_q, lock_q, stage_q, ol_q, mis_q;
  logic [CNT_W-1:0] tmr_q, mask_q;
  hsfs_state_t st_q;
  logic        fault_d;

  hsfs_tick u_tick (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .o_tick    (tick)
  );

  // control register: bit0 command, bit1 cut-off enable
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cmd_q    <= 1'b0;
      cut_en_q <= 1'b1;
    end else if (i_wr && i_addr == REG_CTRL) begin
      cmd_q    <= i_wdata[0];
      cut_en_q <= i_wdata[1];
    end
  end

  // supply lockout with hysteresis
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) lock_q <= 1'b1;
    else if (i_supply_low) lock_q <= 1'b1;
    else if (i_supply_ok) lock_q <= 1'b0;
  end

  // protection state; counters run on the microsecond tick
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_q  <= HSFS_ST_OFF;
      tmr_q <= '0;
    end else begin
      unique case (st_q)
        HSFS_ST_OFF: begin
          if (i_over_temp) st_q <= HSFS_ST_HOT;
          else if (cmd_q && !lock_q) st_q <= HSFS_ST_ON;
        end
        HSFS_ST_ON: begin
          tmr_q <= '0;
          if (i_over_temp) st_q <= HSFS_ST_HOT;
          else if (!cmd_q || lock_q) st_q <= HSFS_ST_OFF;
          else if (i_over_current) st_q <= HSFS_ST_LIMIT;
        end
        HSFS_ST_LIMIT: begin
          if (i_over_temp) st_q <= HSFS_ST_HOT;
          else if (!cmd_q || lock_q) st_q <= HSFS_ST_OFF;
          else if (cut_en_q && tmr_q >= CNT_W'(HOLD_US - 1) && tick) begin
            st_q  <= HSFS_ST_WAIT;
            tmr_q <= '0;
          end else if (!i_over_current) st_q <= HSFS_ST_ON;
          else if (cut_en_q && tick) tmr_q <= tmr_q + 1'b1;
        end
        HSFS_ST_WAIT: begin
          if (i_over_temp) st_q <= HSFS_ST_HOT;
          else if (tick && tmr_q >= CNT_W'(RESTART_US - 1)) st_q <= HSFS_ST_OFF;
          else if (tick) tmr_q <= tmr_q + 1'b1;
        end
        HSFS_ST_HOT: begin
          if (i_temp_cooled && !i_over_temp) st_q <= HSFS_ST_OFF;
        end
      endcase
    end
  end

  // output stage model and open-load mask counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      stage_q <= 1'b0;
      mask_q  <= '0;
      ol_q    <= 1'b0;
    end else begin
      stage_q <= (st_q == HSFS_ST_ON || st_q == HSFS_ST_LIMIT) && cmd_q && !lock_q;
      if (cmd_q || !i_out_high) begin
        mask_q <= '0;
        ol_q   <= 1'b0;
      end else if (mask_q >= CNT_W'(MASK_US)) ol_q <= 1'b1;
      else if (tick) mask_q <= mask_q + 1'b1;
    end
  end

  // expected indicator from faults only, independent of command
  always_comb begin
    fault_d = (st_q == HSFS_ST_HOT) || (st_q == HSFS_ST_WAIT) || ol_q;
  end

  // mismatch between expected and observed indicator, sticky until read
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) mis_q <= 1'b0;
    else if (fault_d == i_fault_indicator_n) mis_q <= 1'b1;
    else if (i_rd && i_addr == REG_STAT) mis_q <= 1'b0;
  end

  // read port, data one cycle after strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) o_rdata <= 32'h0000_0000;
    else if (i_rd && i_addr == REG_CTRL) o_rdata <= {30'h0, cut_en_q, cmd_q};
    else if (i_rd && i_addr == REG_STAT)
      o_rdata <= {25'h0, ~i_fault_indicator_n, mis_q, ol_q,
                  st_q == HSFS_ST_WAIT, st_q == HSFS_ST_HOT, lock_q, stage_q};
    else o_rdata <= 32'h0000_0000;
  end

  // host never pulls the indicator low; only its pull-up role is kept
  assign o_fault_indicator_n_o  = 1'b0;
  assign o_fault_indicator_n_oe = 1'b0;
  assign o_switch_cmd           = cmd_q;
  assign o_out_enable           = stage_q;
  assign o_thermal_flag         = st_q == HSFS_ST_HOT;
  assign o_cutoff_flag          = st_q == HSFS_ST_WAIT;
  assign o_open_load_flag       = ol_q;
  assign o_fault_mismatch       = mis_q;
endmodule

//--- verif/hsfs_asserts.sv
// port checker of the host-side switch supervisor
// assumes one clock with its active-low sync reset
module hsfs_asserts #(parameter int unsigned MASK_US = 200) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_supply_low,
  input wire logic i_over_temp,
  input wire logic i_out_high,
  input wire logic o_switch_cmd,
  input wire logic o_fault_indicator_n_oe,
  input wire logic o_out_enable,
  input wire logic o_thermal_flag,
  input wire logic o_cutoff_flag,
  input wire logic o_open_load_flag
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] ol_q;
  // run of a released output with command low; tick phase costs up to one tick
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !i_out_high || o_switch_cmd) ol_q <= '0;
    else if (ol_q != 16'hffff) ol_q <= ol_q + 16'h0001;
  end
  lockout_off_a: assert property (i_supply_low [*3] |-> !o_out_enable) else $error("lockout");
  thermal_off_a: assert property (i_over_temp [*3] |-> !o_out_enable) else $error("hot on");
  thermal_flag_a: assert property (i_over_temp [*3] |-> o_thermal_flag) else $error("flag");
  hot_stays_off_a: assert property (o_thermal_flag [*2] |-> !o_out_enable) else $error("hot");
  cutoff_off_a: assert property (o_cutoff_flag [*2] |-> !o_out_enable) else $error("cut");
  open_load_on_a: assert property (o_switch_cmd [*3] |-> !o_open_load_flag) else $error("ol");
  ol_clear_a: assert property (!i_out_high [*3] |-> !o_open_load_flag) else $error("olc");
  mask_time_a: assert property ($rose(o_open_load_flag) |-> ol_q >= 16'((MASK_US - 1) * 10))
    else $error("mask");
  no_drive_a: assert property (!o_fault_indicator_n_oe) else $error("pin driven");
  cover property ($rose(o_cutoff_flag));
  cover property ($rose(o_thermal_flag));
  cover property ($rose(o_open_load_flag));
endmodule

bind hsfs_ctrl hsfs_asserts #(.MASK_US(MASK_US)) i_chk (.*);

//--- verif/hsfs_dev_model.sv
// behavioural switch model, fault pin side only
// assumes bench levels; one microsecond is ten clocks
module hsfs_dev_model #(parameter int unsigned MASK_US = 200) (
  input  wire logic i_clk_sys,
  input  wire logic i_cmd,
  input  wire logic i_hot,
  input  wire logic i_cooled,
  input  wire logic i_out_high,
  output logic      o_fault_n
);
  logic        hot_q = 1'h0;
  logic [15:0] ol_q  = 16'h0000;
  // set on trip, kept until the reset level
  always @(posedge i_clk_sys) hot_q <= i_hot | (hot_q & ~i_cooled);
  // command low only, masked for the mask time
  always @(posedge i_clk_sys) begin
    if (i_cmd || !i_out_high) ol_q <= '0;
    else if (ol_q <= 16'(MASK_US * 10)) ol_q <= ol_q + 16'h0001;
  end
  // open drain, pull-up when released, command ignored
  assign o_fault_n = ~(hot_q | (ol_q > 16'(MASK_US * 10)));
endmodule

//--- verif/hsfs_ctrl_bench.sv
// self-checking bench of the host-side switch supervisor
// assumes the device model on the fault pin and short counts
module hsfs_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // short hold stands for a delay capacitor of 0.1 nF, far below the 10 nF minimum
  localparam int unsigned HOLD = 5, MASK = 4;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, sok = 0, slow = 1, hot = 0, cool = 0, oc = 0, oh = 0;
  logic cmd, fault_n, out_en, thermal, cutoff, open_load, mism;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  int failures = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  hsfs_ctrl #(.HOLD_US(HOLD), .RESTART_US(160), .MASK_US(MASK)) i_dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_supply_ok(sok), .i_supply_low(slow), .i_over_temp(hot),
    .i_temp_cooled(cool), .i_over_current(oc), .i_out_high(oh), .o_switch_cmd(cmd),
    .i_fault_indicator_n(fault_n), .o_fault_indicator_n_o(), .o_fault_indicator_n_oe(),
    .o_out_enable(out_en), .o_thermal_flag(thermal), .o_cutoff_flag(cutoff),
    .o_open_load_flag(open_load), .o_fault_mismatch(mism));
  hsfs_dev_model #(.MASK_US(MASK)) i_dev (.i_clk_sys(clk), .i_cmd(cmd), .i_hot(hot),
    .i_cooled(cool), .i_out_high(oh), .o_fault_n(fault_n));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    // read data stand for one cycle; sample them mid-cycle, clear of the edges
    @(negedge clk);
    d = rdata;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] v;
    void'($urandom(98748));
    run(6);
    rst_n <= 1'h1; slow <= 1'h0; sok <= 1'h1;
    rd_reg(4'h0, v);
    chk("ctrl after reset", v, 32'h0000_0002);
    wr_reg(4'h0, 32'h0000_0003);
    run(4);
    chk("stage", out_en, 1'h1);
    chk("command pin", cmd, 1'h1);
    chk("mismatch", mism, 1'h0);
    slow <= 1'h1; sok <= 1'h0;
    run(4);
    chk("stage", out_en, 1'h0);
    rd_reg(4'h4, v);
    chk("lockout", v[1], 1'h1);
    slow <= 1'h0;
    run(4);
    chk("stage", out_en, 1'h0);
    sok <= 1'h1;
    run(4);
    chk("stage", out_en, 1'h1);
    hot <= 1'h1;
    run(4);
    chk("thermal", thermal, 1'h1);
    chk("stage", out_en, 1'h0);
    hot <= 1'h0;
    run(20 + $urandom_range(30));
    chk("stage", out_en, 1'h0);
    cool <= 1'h1;
    run(4);
    cool <= 1'h0;
    chk("thermal", thermal, 1'h0);
    chk("stage", out_en, 1'h1);
    oc <= 1'h1;
    run(HOLD * 10 + 30);
    chk("cutoff", cutoff, 1'h1);
    chk("stage", out_en, 1'h0);
    oc <= 1'h0;
    run(1000);
    chk("cutoff", cutoff, 1'h1);
    run(700);
    chk("cutoff", cutoff, 1'h0);
    wr_reg(4'h0, 32'h0000_0001);
    oc <= 1'h1;
    run(HOLD * 30);
    chk("stage", out_en, 1'h1);
    oc <= 1'h0;
    wr_reg(4'h0, 32'h0000_0002);
    repeat (4) begin
      oh <= 1'h1;
      run($urandom_range(MASK * 10 - 15, 1));
      oh <= 1'h0;
      run(2);
      chk("open load", open_load, 1'h0);
    end
    oh <= 1'h1;
    run(MASK * 10 + 20);
    chk("open load", open_load, 1'h1);
    wr_reg(4'h0, 32'h0000_0003);
    run(4);
    chk("open load", open_load, 1'h0);
    wr_reg(4'h0, 32'h0000_0002);
    run(MASK * 10 + 20);
    oh <= 1'h0;
    run(4);
    chk("open load", open_load, 1'h0);
    rd_reg(4'h8, v);
    chk("unmapped", v, 32'h0000_0000);
    report_and_stop();
  end
endmodule
